// ===== design/scrb_config_regs.sv
// configuration register bank reached by monitor channel commands
// assumes a deframed byte channel: one-cycle rx strobes, tx handshake
`timescale 1ns/1ps
`include "scrb_params.svh"
module scrb_config_regs import scrb_pkg::*; #(
  parameter int MS_CYCLES = `SCRB_MS_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // downstream monitor bytes
  input wire logic mon_rx_valid,
  input wire logic [7:0] mon_rx_data,
  input wire logic mon_rx_eom,
  // upstream monitor bytes
  output logic mon_tx_valid,
  output logic [7:0] mon_tx_data,
  input wire logic mon_tx_ready,
  // measurement engine results
  input wire logic meas_done,
  input wire logic tone_level_in,
  input wire logic metering_in,
  input wire logic ring_level_in,
  // signalling pins
  input wire logic hook_pin,
  input wire logic gndkey_pin,
  // general-purpose pins
  input wire logic gp_pin_a_in,
  output logic gp_pin_a_out,
  output logic gp_pin_a_oe,
  input wire logic gp_pin_b_in,
  output logic gp_pin_b_out,
  output logic gp_pin_b_oe,
  input wire logic [1:0] gp_drive,
  // forwarded signalling and settings
  output logic hook_state,
  output logic aux_state,
  output logic gndkey_state,
  output logic gp_b_level,
  output logic pol_reverse,
  output logic basic_mode,
  output scrb_cfg_s cfg,
  output scrb_phys_s phys
);
  localparam int MSW = $clog2(MS_CYCLES);

  logic [7:0] cr_ff [2:11];
  logic meas_valid_ff;
  logic tone_level_ok_ff;
  logic metering_ok_ff;
  logic ring_level_ok_ff;
  scrb_state_e state_ff;
  logic [3:0] idx_ff;
  logic [3:0] last_ff;
  logic [7:0] prev_sop_ff;
  logic [7:0] rep_sop_ff;
  logic pol_ff;
  logic rst_flag_ff;
  logic tx_valid_ff;
  logic [7:0] tx_data_ff;
  logic wr_en;
  logic soft_rst;
  logic cr2_wr;
  logic [MSW-1:0] ms_cnt_ff;
  logic tick_ff;
  logic [2:0] pin_lvl;
  logic [1:0] gp_out_ff;
  scrb_cfg_s cfg_ff;
  scrb_phys_s phys_ff;

  // default contents of each register
  function automatic logic [7:0] cr_reset(input int i);
    case (i)
      2: cr_reset = `SCRB_RST_CR2;
      3: cr_reset = `SCRB_RST_CR3;
      4: cr_reset = `SCRB_RST_CR4;
      5: cr_reset = `SCRB_RST_CR5;
      6: cr_reset = `SCRB_RST_CR6;
      7: cr_reset = `SCRB_RST_CR7;
      8: cr_reset = `SCRB_RST_CR8;
      9: cr_reset = `SCRB_RST_CR9;
      10: cr_reset = `SCRB_RST_TELETAX_LEVEL;
      11: cr_reset = `SCRB_RST_EXT_INDICATION_THRESHOLD;
      default: cr_reset = 8'h00;
    endcase
  endfunction

  // 6-bit current code to tenths of a milliamp, active and standby alike
  function automatic logic [9:0] clim_dma(input logic [5:0] code);
    clim_dma = 10'({4'h0, code} * `SCRB_CLIM_STEP);
  endfunction

  // readback of one register; CR1 and CR12 live elsewhere and read zero
  function automatic logic [7:0] cr_read(input logic [3:0] i);
    case (i)
      4'h2: cr_read = {meas_valid_ff, tone_level_ok_ff, metering_ok_ff,
                       ring_level_ok_ff, cr_ff[2][3:0]};
      4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'hA: cr_read = cr_ff[i];
      4'hB: cr_read = {cr_ff[11][7:1], 1'b0};
      default: cr_read = 8'h00;
    endcase
  endfunction

  // write strobe while the data phase of a write command runs
  // the byte flagged as last still carries register data
  assign wr_en = (state_ff == ST_WDATA) && mon_rx_valid;
  assign cr2_wr = wr_en && (idx_ff == 4'h2);
  // a write command with its reset bit set restores the basic setting
  assign soft_rst = (state_ff == ST_CMD) && mon_rx_valid &&
                    (mon_rx_data[3:2] == `SCRB_SOP_ID) &&
                    !mon_rx_data[`SCRB_SOP_RW] && mon_rx_data[`SCRB_SOP_RST];

  // register storage, only reachable from the command decoder
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 2; i <= 11; i++) begin
        cr_ff[i] <= cr_reset(i);
      end
    end else if (soft_rst) begin
      for (int i = 2; i <= 11; i++) begin
        cr_ff[i] <= cr_reset(i);
      end
    end else if (wr_en) begin
      for (int i = 2; i <= 11; i++) begin
        if (idx_ff == 4'(i)) begin
          cr_ff[i] <= mon_rx_data;
        end
      end
    end
  end

  // result flags: a write to the test register voids them, a result sets
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meas_valid_ff <= 1'b0;
      tone_level_ok_ff <= 1'b0;
      metering_ok_ff <= 1'b0;
      ring_level_ok_ff <= 1'b0;
    end else begin
      if (cr2_wr || soft_rst) begin
        meas_valid_ff <= 1'b0;
      end
      // set after clear so a result in the same cycle survives
      if (meas_done && cr_ff[2][`SCRB_B_TEST_RUN]) begin
        meas_valid_ff <= 1'b1;
        tone_level_ok_ff <= tone_level_in;
        metering_ok_ff <= metering_in;
        ring_level_ok_ff <= ring_level_in;
      end
    end
  end

  // command decoder and upstream reply sequencer
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_ff <= ST_IDLE;
      idx_ff <= 4'h0;
      last_ff <= 4'h0;
      prev_sop_ff <= 8'h00;
      rep_sop_ff <= 8'h00;
      pol_ff <= 1'b0;
      rst_flag_ff <= 1'b1;
      tx_valid_ff <= 1'b0;
      tx_data_ff <= 8'h00;
    end else begin
      case (state_ff)
        ST_IDLE: begin
          if (mon_rx_valid && !mon_rx_eom &&
              mon_rx_data == `SCRB_MON_ADDR) begin
            state_ff <= ST_CMD;
          end
        end
        ST_CMD: begin
          if (mon_rx_valid) begin
            if (mon_rx_data[3:2] != `SCRB_SOP_ID) begin
              // coefficient commands belong to the filter block
              state_ff <= mon_rx_eom ? ST_IDLE : ST_SKIP;
            end else begin
              prev_sop_ff <= mon_rx_data;
              rep_sop_ff <= {prev_sop_ff[7:5], rst_flag_ff,
                             prev_sop_ff[3:0]};
              idx_ff <= 4'h1;
              state_ff <= ST_IDLE;
              if (!mon_rx_data[`SCRB_SOP_RW]) begin
                pol_ff <= mon_rx_data[`SCRB_SOP_POL];
                if (mon_rx_data[`SCRB_SOP_RST]) begin
                  rst_flag_ff <= 1'b1;
                end
                if (mon_rx_data[1:0] == `SCRB_LSEL_TWO) begin
                  last_ff <= `SCRB_LAST_TWO;
                  state_ff <= ST_WDATA;
                end else if (mon_rx_data[1:0] == `SCRB_LSEL_ALL) begin
                  last_ff <= `SCRB_LAST_ALL;
                  state_ff <= ST_WDATA;
                end
              end else if (mon_rx_data[1:0] != 2'h3) begin
                // reply: address, previous command, then registers
                idx_ff <= 4'h0;
                state_ff <= ST_REPLY;
                case (mon_rx_data[1:0])
                  `SCRB_LSEL_NONE: begin
                    last_ff <= 4'h1;
                    rst_flag_ff <= 1'b0;
                  end
                  `SCRB_LSEL_TWO: last_ff <= 4'h3;
                  default: last_ff <= 4'hD;
                endcase
              end
            end
          end
        end
        ST_WDATA: begin
          if (mon_rx_valid) begin
            idx_ff <= idx_ff + 4'h1;
            if (mon_rx_eom || idx_ff == last_ff) begin
              state_ff <= ST_IDLE;
            end
          end
        end
        ST_REPLY: begin
          // downstream bytes are ignored while a reply drains
          if (!tx_valid_ff || mon_tx_ready) begin
            if (idx_ff > last_ff) begin
              tx_valid_ff <= 1'b0;
              state_ff <= ST_IDLE;
            end else begin
              tx_valid_ff <= 1'b1;
              idx_ff <= idx_ff + 4'h1;
              if (idx_ff == 4'h0) begin
                tx_data_ff <= `SCRB_MON_ADDR;
              end else if (idx_ff == 4'h1) begin
                tx_data_ff <= rep_sop_ff;
              end else begin
                tx_data_ff <= cr_read(idx_ff - 4'h1);
              end
            end
          end
        end
        ST_SKIP: begin
          if (mon_rx_valid && mon_rx_eom) begin
            state_ff <= ST_IDLE;
          end
        end
        default: state_ff <= ST_IDLE;
      endcase
    end
  end

  // free-running millisecond tick for the persistence checks
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ms_cnt_ff <= '0;
      tick_ff <= 1'b0;
    end else if (ms_cnt_ff == MSW'(MS_CYCLES - 1)) begin
      ms_cnt_ff <= '0;
      tick_ff <= 1'b1;
    end else begin
      ms_cnt_ff <= ms_cnt_ff + MSW'(1);
      tick_ff <= 1'b0;
    end
  end

  // pin inputs cross into the clock domain
  scrb_sync3 #(.WIDTH(3)) u_sync (
    .clk(clk),
    .rst_b(rst_b),
    .pin_in({hook_pin, gndkey_pin, gp_pin_a_in}),
    .level_ff(pin_lvl)
  );

  // hook and auxiliary input held N ticks
  scrb_persist u_hook (
    .clk(clk),
    .rst_b(rst_b),
    .tick(tick_ff),
    .limit({2'h0, cr_ff[3][7:4]}),
    .level(pin_lvl[2]),
    .state_ff(hook_state)
  );

  scrb_persist u_aux (
    .clk(clk),
    .rst_b(rst_b),
    .tick(tick_ff),
    .limit({2'h0, cr_ff[3][7:4]}),
    .level(pin_lvl[0] & ~cr_ff[2][`SCRB_B_DIR_A]),
    .state_ff(aux_state)
  );

  // ground key held four ticks per code step
  scrb_persist u_gndkey (
    .clk(clk),
    .rst_b(rst_b),
    .tick(tick_ff),
    .limit({cr_ff[3][3:0], 2'h0}),
    .level(pin_lvl[1]),
    .state_ff(gndkey_state)
  );

  // second general-purpose pin only reported, not persistence checked
  scrb_sync3 #(.WIDTH(1)) u_sync_b (
    .clk(clk),
    .rst_b(rst_b),
    .pin_in(gp_pin_b_in),
    .level_ff(gp_b_level)
  );

  // general-purpose pin drive registered
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      gp_out_ff <= 2'h0;
    end else begin
      gp_out_ff <= gp_drive;
    end
  end

  // raw control fields registered for the datapath
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cfg_ff <= '0;
    end else begin
      cfg_ff.test_run <= cr_ff[2][`SCRB_B_TEST_RUN];
      cfg_ff.test_sel <= (cr_ff[2][`SCRB_B_TEST_RUN] &&
                          cr_ff[5][3:0] != `SCRB_TEST_UNUSED) ?
                         cr_ff[5][3:0] : 4'h0;
      cfg_ff.metering_hard_switch <= cr_ff[2][`SCRB_B_HARD_SW];
      cfg_ff.filt_en <= cr_ff[4][7:3];
      cfg_ff.loopback_sel <= cr_ff[4][2:1];
      cfg_ff.alaw <= cr_ff[4][0];
      cfg_ff.coeff_source <= cr_ff[6][0];
      cfg_ff.state_select_aux <= cr_ff[7][1];
      cfg_ff.ring_trip_test_en <= cr_ff[7][0];
      cfg_ff.meter_freq_sel <= cr_ff[8][4];
      cfg_ff.meter_by_reversal <= cr_ff[8][3];
      cfg_ff.soft_reversal <= cr_ff[8][2];
      cfg_ff.ring_source_sel <= cr_ff[8][1];
      cfg_ff.meas_modulation <= cr_ff[8][0];
      cfg_ff.rx_highpass_off <= cr_ff[11][1];
      cfg_ff.meter_level_code <= cr_ff[10];
    end
  end

  // physical settings decoded once, registered
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      phys_ff <= '0;
    end else begin
      phys_ff.ring_trip_16th <= {1'b0, cr_ff[5][7:4]} + 5'h01;
      phys_ff.active_climit_dma <= clim_dma(cr_ff[6][7:2]);
      phys_ff.active_hook_ma <= cr_ff[6][1] ? `SCRB_HOOK_HI_MA :
                                `SCRB_HOOK_LO_MA;
      phys_ff.standby_climit_dma <= clim_dma(cr_ff[7][7:2]);
      phys_ff.feed_res_ohm <= 10'(({7'h00, cr_ff[8][7:5]} + 10'h001) *
                                  `SCRB_FEED_STEP);
      phys_ff.ring_amp_mv <= cr_ff[9][7] ?
        17'(`SCRB_RING_HI_BASE + {13'h0, cr_ff[9][3:0]} *
            `SCRB_RING_HI_STEP) :
        17'(`SCRB_RING_LO_BASE + {13'h0, cr_ff[9][3:0]} *
            `SCRB_RING_LO_STEP);
      phys_ff.ring_freq_code <= cr_ff[9][6:4];
      phys_ff.ring_freq_ok <= cr_ff[9][6:4] <= `SCRB_RFREQ_MAX;
      phys_ff.meter_drop_code <= cr_ff[10][7:3];
      phys_ff.ext_thresh_v <= (cr_ff[11][7:4] == 4'h0) ? 5'h00 :
        `SCRB_EXT_IND_THRESH_BASE + {1'b0, cr_ff[11][7:4]};
    end
  end

  // outputs straight from flops
  assign mon_tx_valid = tx_valid_ff;
  assign mon_tx_data = tx_data_ff;
  assign gp_pin_a_oe = cr_ff[2][`SCRB_B_DIR_A];
  assign gp_pin_b_oe = cr_ff[2][`SCRB_B_DIR_B];
  assign gp_pin_a_out = gp_out_ff[0];
  assign gp_pin_b_out = gp_out_ff[1];
  assign pol_reverse = pol_ff;
  assign basic_mode = rst_flag_ff;
  assign cfg = cfg_ff;
  assign phys = phys_ff;

  // checks on the bank's own behaviour
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  AST_VALID_VOID: assert property (
    cr2_wr && !meas_done |=> !meas_valid_ff ##1
    (!meas_valid_ff || $past(meas_done)))
    else $error("result flag valid after test register write");
  AST_TEST_STOP: assert property (
    $fell(cr_ff[2][`SCRB_B_TEST_RUN]) |=> cfg.test_run == 1'b0 &&
    cfg.test_sel == 4'h0)
    else $error("test still selected after stop");
  AST_GP_DIR: assert property (
    $stable(cr_ff[2]) |-> gp_pin_a_oe == cr_ff[2][1] &&
    gp_pin_b_oe == cr_ff[2][0])
    else $error("pin direction does not follow register");
  AST_HOOK_TICK: assert property (
    !$stable(hook_state) && cr_ff[3][7:4] != 4'h0 |-> $past(tick_ff))
    else $error("hook state moved without a millisecond tick");
  AST_LAW: assert property (
    $changed(cr_ff[4][0]) |=> cfg.alaw == $past(cr_ff[4][0]))
    else $error("coding law not applied");
  AST_CLIM: assert property (
    $past(rst_b) |->
    phys.active_climit_dma == 10'($past(cr_ff[6][7:2]) * 11))
    else $error("active current limit scaling wrong");
  AST_EXT_IND_THRESH_ZERO: assert property (
    $past(rst_b) && $past(cr_ff[11][7:4]) == 4'h0 |->
    phys.ext_thresh_v == 5'h00)
    else $error("zero threshold code not 0V");
  AST_EXT_IND_THRESH_STEP: assert property (
    $past(rst_b) && $past(cr_ff[11][7:4]) != 4'h0 |->
    phys.ext_thresh_v == 5'd8 + {1'b0, $past(cr_ff[11][7:4])})
    else $error("threshold not 8V plus code");
  AST_NO_UNUSED: assert property (
    cfg.test_sel != 4'h8)
    else $error("unused test mode reached datapath");
  AST_REPLY_ADDR: assert property (
    state_ff == ST_CMD && mon_rx_valid && mon_rx_data[3:2] == 2'h1 &&
    mon_rx_data[6] && mon_rx_data[1:0] != 2'h3 && !tx_valid_ff
    |=> ##1 tx_valid_ff && tx_data_ff == 8'h81)
    else $error("read command did not start reply with address");

  COV_WRITE_ALL: cover property (
    state_ff == ST_WDATA && wr_en && idx_ff == 4'hC);
  COV_READ_ALL: cover property (
    state_ff == ST_REPLY && tx_valid_ff && mon_tx_ready && idx_ff == 4'hE);
  COV_MEAS: cover property (meas_done && cr_ff[2][3]);
endmodule

// ===== design/scrb_params.svh
// constants for the line-interface configuration register bank
// assumes an 8 ns device clock and a deframed monitor byte channel
//
// Operation
// - valid flag qualifies the three result flags
// - test_run one starts, zero stops tests
// - direction bit zero input, one output
// - hook and aux forwarded after N ms
// - ground key forwarded after 4N ms
// - persistence register resets to A5
// - filter enable bits apply programmed coefficients
// - two-bit loop-back path select
// - coding law zero mu, one A
// - ring-trip threshold code plus one sixteenths
// - test select picks mode, 8h unused
// - active current limit code times 1.1mA
// - off-hook threshold 10mA or 13mA
// - coefficient source programmed or fixed
// - standby limit field, reset value 1Ch
// - feed resistance 100 ohm times code+1
// - metering frequency, reversal and shaping bits
// - ringing source internal or external pin
// - ring amplitude base plus code step
// - ring frequency codes 5h-7h unused
// - teletax level and DC drop code
// - external threshold code zero gives 0V
// - nonzero code gives 8V plus code
// - rx high-pass disable bit bypasses filter
// - access only through status/operation command
`ifndef SCRB_PARAMS_SVH
`define SCRB_PARAMS_SVH
// monitor channel framing
`define SCRB_MON_ADDR 8'h81
`define SCRB_SOP_RW 6
`define SCRB_SOP_POL 5
`define SCRB_SOP_RST 4
`define SCRB_SOP_ID 2'h1
`define SCRB_LSEL_NONE 2'h0
`define SCRB_LSEL_TWO 2'h1
`define SCRB_LSEL_ALL 2'h2
`define SCRB_LAST_TWO 4'h2
`define SCRB_LAST_ALL 4'hC
// register reset values
`define SCRB_RST_CR2 8'h00
`define SCRB_RST_CR3 8'hA5
`define SCRB_RST_CR4 8'hF9
`define SCRB_RST_CR5 8'h60
`define SCRB_RST_CR6 8'h51
`define SCRB_RST_CR7 8'h1C
`define SCRB_RST_CR8 8'h00
`define SCRB_RST_CR9 8'h2F
`define SCRB_RST_TELETAX_LEVEL 8'hFF
`define SCRB_RST_EXT_INDICATION_THRESHOLD 8'h10
// test register field positions
`define SCRB_B_VALID 7
`define SCRB_B_TONE_OK 6
`define SCRB_B_METER_OK 5
`define SCRB_B_RING_OK 4
`define SCRB_B_TEST_RUN 3
`define SCRB_B_HARD_SW 2
`define SCRB_B_DIR_A 1
`define SCRB_B_DIR_B 0
`define SCRB_TEST_UNUSED 4'h8
`define SCRB_RFREQ_MAX 3'h4
// physical scaling
`define SCRB_CLIM_STEP 10'h00B
`define SCRB_FEED_STEP 10'h064
`define SCRB_RING_LO_BASE 17'h08660
`define SCRB_RING_LO_STEP 17'h007F7
`define SCRB_RING_HI_BASE 17'h0AFC8
`define SCRB_RING_HI_STEP 17'h00A64
`define SCRB_EXT_IND_THRESH_BASE 5'h08
`define SCRB_HOOK_LO_MA 4'hA
`define SCRB_HOOK_HI_MA 4'hD
// timing
`define SCRB_MS_NS 1000000
`define SCRB_CLK_NS 8
`define SCRB_MS_CYCLES (`SCRB_MS_NS / `SCRB_CLK_NS)
`endif

// ===== design/scrb_persist.sv
// persistence check on one signalling level
// assumes a one-cycle millisecond tick on the same clock
`timescale 1ns/1ps
module scrb_persist (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // timing and limit in ticks, zero means no check
  input wire logic tick,
  input wire logic [5:0] limit,
  // level in and forwarded level
  input wire logic level,
  output logic state_ff
);
  logic [5:0] cnt_ff;

  // first tick is partial, so the hold lands between limit-1 and limit ms
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_ff <= 6'h00;
      state_ff <= 1'b0;
    end else if (level == state_ff) begin
      cnt_ff <= 6'h00;
    end else if (limit == 6'h00) begin
      state_ff <= level;
    end else if (tick) begin
      if (cnt_ff + 6'h01 >= limit) begin
        state_ff <= level;
        cnt_ff <= 6'h00;
      end else begin
        cnt_ff <= cnt_ff + 6'h01;
      end
    end
  end
endmodule

// ===== design/scrb_pkg.sv
// types shared by the configuration register bank
// no assumptions beyond the params header
package scrb_pkg;
  typedef enum logic [2:0] {
    ST_IDLE, ST_CMD, ST_WDATA, ST_REPLY, ST_SKIP
  } scrb_state_e;

  // raw control fields for the datapath
  typedef struct packed {
    logic [3:0] test_sel;
    logic test_run;
    logic metering_hard_switch;
    logic [4:0] filt_en;
    logic [1:0] loopback_sel;
    logic alaw;
    logic coeff_source;
    logic state_select_aux;
    logic ring_trip_test_en;
    logic meter_freq_sel;
    logic meter_by_reversal;
    logic soft_reversal;
    logic ring_source_sel;
    logic meas_modulation;
    logic rx_highpass_off;
    logic [7:0] meter_level_code;
  } scrb_cfg_s;

  // decoded physical settings
  typedef struct packed {
    logic [4:0] ring_trip_16th;
    logic [9:0] active_climit_dma;
    logic [3:0] active_hook_ma;
    logic [9:0] standby_climit_dma;
    logic [9:0] feed_res_ohm;
    logic [16:0] ring_amp_mv;
    logic [2:0] ring_freq_code;
    logic ring_freq_ok;
    logic [4:0] meter_drop_code;
    logic [4:0] ext_thresh_v;
  } scrb_phys_s;
endpackage

// ===== design/scrb_sync3.sv
// three-stage synchroniser for pin inputs
// assumes asynchronous pins; output moves when stages two and three agree
`timescale 1ns/1ps
module scrb_sync3 #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // pins and result
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] level_ff
);
  logic [WIDTH-1:0] s1_ff;
  logic [WIDTH-1:0] s2_ff;
  logic [WIDTH-1:0] s3_ff;

  // first stage feeds only the second
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s1_ff <= '0;
      s2_ff <= '0;
      s3_ff <= '0;
      level_ff <= '0;
    end else begin
      s1_ff <= pin_in;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      for (int i = 0; i < WIDTH; i++) begin
        if (s2_ff[i] == s3_ff[i]) begin
          level_ff[i] <= s3_ff[i];
        end
      end
    end
  end
endmodule

// ===== tb/scrb_config_regs_tb_top.sv
// self-checking bench for the configuration register bank
// assumes the controller model drives the monitor byte channel
`timescale 1ns/1ps
module scrb_config_regs_tb_top import scrb_pkg::*;;
  logic clk, rst_b, rx_v, rx_eom, tx_v, tx_rdy, done;
  logic [7:0] rx_d, tx_d;
  logic tone, meter, ring, hook, gkey;
  logic a_out, a_oe, b_out, b_oe, hook_st, gkey_st;
  logic aux_st, gb, pol, basic;
  logic [1:0] drive;
  scrb_cfg_s cfg;
  scrb_phys_s phys;
  logic [7:0] cr [12];
  int fail_count = 0;
  int n_compared = 0;
  scrb_ctrl_model i_ctrl (.clk(clk), .mon_rx_valid(rx_v),
    .mon_rx_data(rx_d), .mon_rx_eom(rx_eom), .mon_tx_valid(tx_v),
    .mon_tx_data(tx_d), .mon_tx_ready(tx_rdy));
  scrb_config_regs #(.MS_CYCLES(20)) i_dut (.clk(clk), .rst_b(rst_b),
    .mon_rx_valid(rx_v), .mon_rx_data(rx_d), .mon_rx_eom(rx_eom),
    .mon_tx_valid(tx_v), .mon_tx_data(tx_d), .mon_tx_ready(tx_rdy),
    .meas_done(done), .tone_level_in(tone), .metering_in(meter),
    .ring_level_in(ring), .hook_pin(hook), .gndkey_pin(gkey),
    .gp_pin_a_in(hook), .gp_pin_a_out(a_out), .gp_pin_a_oe(a_oe),
    .gp_pin_b_in(gkey), .gp_pin_b_out(b_out), .gp_pin_b_oe(b_oe),
    .gp_drive(drive), .hook_state(hook_st), .aux_state(aux_st),
    .gndkey_state(gkey_st), .gp_b_level(gb), .pol_reverse(pol),
    .basic_mode(basic), .cfg(cfg), .phys(phys));
  // clock and watchdog
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    #400000;
    fail_count++;
    summarize();
  end
  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // full write of CR1..CR12 from the bench image
  task automatic wr_all();
    i_ctrl.msg('{8'h81, 8'h06, cr[0], cr[1], cr[2], cr[3], cr[4],
      cr[5], cr[6], cr[7], cr[8], cr[9], cr[10], cr[11]});
    repeat (3) @(posedge clk);
  endtask
  // full read; CR1/CR12 held elsewhere read 00, EXT_INDICATION_THRESHOLD bit0 reads 0
  task automatic rd_all(input logic [7:0] cr2);
    int k;
    i_ctrl.rx_q.delete();
    i_ctrl.msg('{8'h81, 8'h46});
    k = 0;
    while (i_ctrl.rx_q.size() < 14 && k < 300) begin
      @(posedge clk);
      k++;
    end
    if (k == 300) begin
      fail_count++;
      summarize();
    end
    @(posedge clk);
    chk(i_ctrl.rx_q[0], 8'h81);
    chk(i_ctrl.rx_q[2], 8'h00);
    chk(i_ctrl.rx_q[3], cr2);
    for (int i = 2; i < 11; i++)
      chk(i_ctrl.rx_q[i + 2], (i == 10) ? cr[i] & 8'hFE : cr[i]);
    chk(i_ctrl.rx_q[13], 8'h00);
  endtask
  // raise a pin, time its forwarding against the persistence window
  task automatic persist(input bit gk, input int lo, input int hi);
    int k;
    @(posedge clk);
    if (gk)
      gkey <= 1'b1;
    else
      hook <= 1'b1;
    k = 0;
    while ((gk ? gkey_st : hook_st) !== 1'b1 && k < 200) begin
      @(posedge clk);
      k++;
    end
    n_compared++;
    if (k < lo || k > hi) begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, k, lo);
    end
  endtask
  // main sequence
  initial begin
    rst_b = 1'b0;
    {done, tone, meter, ring, hook, gkey} = 6'h00;
    drive = 2'h3;
    cr = '{8'h00, 8'h00, 8'hA5, 8'hF9, 8'h60, 8'h51, 8'h1C, 8'h00,
      8'h2F, 8'hFF, 8'h10, 8'h00};
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    rd_all(8'h00);
    chk({basic, pol}, 2'b10);
    $display("test reset defaults done");
    // reserved threshold bits kept zero by the controller
    cr = '{8'h5A, 8'h0E, 8'h21, 8'h06, 8'hF8, 8'hFE, 8'h03, 8'hE5,
      8'hD5, 8'h9C, 8'h02, 8'h77};
    wr_all();
    chk(cfg.test_sel, 4'h0);
    chk(cfg.test_run, 1'b1);
    chk(phys.ring_trip_16th, 5'h0F + 5'h01);
    chk(phys.active_climit_dma, 32'(6'h3F) * 11);
    chk(phys.active_hook_ma, 4'hD);
    chk(phys.feed_res_ohm, 100 * (7 + 1));
    chk(phys.ring_amp_mv, 45000 + 5 * 2660);
    chk(phys.ring_freq_ok, 1'b0);
    chk(phys.meter_drop_code, 8'h9C >> 3);
    chk(phys.ext_thresh_v, 5'h00);
    chk({a_oe, b_oe, a_out, b_out}, 4'b1011);
    chk({cfg.filt_en, cfg.loopback_sel, cfg.alaw}, 8'h06);
    chk(cfg.rx_highpass_off, 1'b1);
    chk({cfg.meter_freq_sel, cfg.meter_by_reversal, cfg.soft_reversal,
      cfg.ring_source_sel}, 4'b0010);
    $display("test full write done");
    // result flags, then a CR2 write clears the valid flag, reply stalled
    @(posedge clk);
    {done, tone, meter, ring} <= 4'b1101;
    @(posedge clk);
    done <= 1'b0;
    i_ctrl.slow = 1'b1;
    rd_all(8'hDE);
    cr[4] = 8'h3F;
    cr[10] = 8'h50;
    cr[5] = 8'h01;
    wr_all();
    // ok flags keep stale values while the valid flag is low
    rd_all(8'h5E);
    i_ctrl.slow = 1'b0;
    chk(cfg.test_sel, 4'hF);
    chk(cfg.coeff_source, 1'b1);
    chk(phys.ext_thresh_v, 8 + 5);
    // two-byte write stops the test and frees both pins
    i_ctrl.msg('{8'h81, 8'h25, 8'h00, 8'h04});
    repeat (3) @(posedge clk);
    chk({cfg.test_run, cfg.test_sel}, 5'h00);
    chk({a_oe, b_oe, pol}, 3'b001);
    chk(cfg.metering_hard_switch, 1'b1);
    $display("test results and thresholds done");
    // hook 2 ms, ground key 4 ms at 20 cycles per ms
    persist(1'b0, 20, 46);
    persist(1'b1, 60, 86);
    chk({aux_st, gb}, 2'b11);
    $display("test persistence done");
    summarize();
  end
endmodule

// ===== tb/scrb_ctrl_model.sv
// line card controller model on the monitor byte channel
// assumes the bank samples one downstream byte per rising edge
`timescale 1ns/1ps
module scrb_ctrl_model (
  // clock
  input wire logic clk,
  // downstream bytes
  output logic mon_rx_valid,
  output logic [7:0] mon_rx_data,
  output logic mon_rx_eom,
  // upstream bytes
  input wire logic mon_tx_valid,
  input wire logic [7:0] mon_tx_data,
  output logic mon_tx_ready
);
  logic [7:0] rx_q[$];
  logic slow = 1'b0;
  initial begin
    mon_rx_valid = 1'b0;
    mon_rx_data = 8'h00;
    mon_rx_eom = 1'b0;
    mon_tx_ready = 1'b0;
  end
  // one whole message, bytes on successive edges
  task automatic msg(input logic [7:0] q[$]);
    foreach (q[i]) begin
      @(posedge clk);
      mon_rx_valid <= 1'b1;
      mon_rx_data <= q[i];
      mon_rx_eom <= (i == q.size() - 1);
    end
    @(posedge clk);
    mon_rx_valid <= 1'b0;
    mon_rx_data <= ~q[q.size() - 1]; // released bus must not echo
    mon_rx_eom <= 1'b0;
  endtask
  // reply capture; slow mode stalls every other cycle
  always @(posedge clk) begin
    if (mon_tx_valid && mon_tx_ready)
      rx_q.push_back(mon_tx_data);
    mon_tx_ready <= slow ? ~mon_tx_ready : 1'b1;
  end
endmodule
